// ===== design/bpp_pkg.sv
// Package: register map, field positions and carriers for the GPIO port
package bpp_pkg;
  localparam logic [3:0] ADDR_PORT = 4'h0;
  localparam logic [3:0] ADDR_LAT = 4'h4;
  localparam logic [3:0] ADDR_DIR = 4'h8;
  localparam logic [3:0] ADDR_INTC = 4'hC;
  localparam logic [7:0] DIR_RESET = 8'hFF;
  localparam logic [7:0] LAT_RESET = 8'h00;
  localparam logic [7:0] INTC_RESET = 8'h80;
  localparam int INTC_PU_N_BIT = 7;
  localparam int INTC_FLAG_BIT = 0;
  localparam int CHG_LO = 4;
  localparam int CCP_PIN = 3;
  localparam int PGC_PIN = 6;
  localparam int PGD_PIN = 7;
  localparam int FLT_PIN = 0;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe_n;
    logic [7:0] pull_en;
  } bpp_pad_s;

  typedef struct packed {
    logic map_cfg_n;
    logic ccp_oe;
    logic ccp_out;
    logic pwm_sel;
    logic pwm_tri;
  } bpp_ccp_s;
endpackage : bpp_pkg

// ===== design/bpp_port.sv
// GPIO port top: Wishbone registers, pad control, change detection
//
// Our own choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/100ps
module bpp_port (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic move_src_i,
  input wire logic [7:0] pin_i,
  output logic [7:0] pin_o,
  output logic [7:0] pin_oe_n_o,
  output logic [7:0] pull_en_o,
  input wire bpp_pkg::bpp_ccp_s ccp_i,
  input wire logic fault_en_i,
  input wire logic prog_en_i,
  input wire logic prog_data_out_i,
  input wire logic prog_data_oe_i,
  output logic [3:0] ext_irq_o,
  output logic ccp_capture_o,
  output logic pwm_fault_o,
  output logic prog_serial_clock_o,
  output logic prog_serial_data_o,
  output logic port_change_flag_o,
  output logic wake_o
);
  logic [7:0] lat_q;
  logic [7:0] dir_q;
  logic pu_n_q;
  logic flag_q;
  logic [7:0] samp_q;
  logic [3:0] snap_q;
  logic ack_q;
  logic [31:0] rdat_q;
  bpp_pkg::bpp_pad_s pad_q;
  bpp_pkg::bpp_pad_s pad_d;
  logic [3:0] irq_q;
  logic cap_q;
  logic flt_q;
  logic pgc_q;
  logic pgd_q;

  // Decode: ack only on the first cycle, so every access takes effect once
  wire req = wb_cyc_i & wb_stb_i & ~ack_q;
  wire wr = req & wb_we_i & wb_sel_i[0];
  wire sel_port = wb_adr_i == bpp_pkg::ADDR_PORT;
  wire sel_lat = wb_adr_i == bpp_pkg::ADDR_LAT;
  wire sel_dir = wb_adr_i == bpp_pkg::ADDR_DIR;
  wire sel_intc = wb_adr_i == bpp_pkg::ADDR_INTC;
  // Move instruction reading the port does not refresh the snapshot
  wire port_touch = req & sel_port & ~(move_src_i & ~wb_we_i);
  wire [7:0] intc_rd = {pu_n_q, 6'h00, flag_q};

  wire [7:0] rd_mux = sel_port ? samp_q :
                      sel_lat ? lat_q :
                      sel_dir ? dir_q :
                      sel_intc ? intc_rd : 8'h00;

  // Compare only upper pins that are inputs
  wire [3:0] mism = (samp_q[7:4] ^ snap_q) & dir_q[7:4];
  wire any_mism = |mism;

  // Channel 2 mapped to pin 3 only when the map bit is clear
  wire ccp_map = ~ccp_i.map_cfg_n;
  wire ccp_drv = ccp_map & ccp_i.ccp_oe & ~dir_q[bpp_pkg::CCP_PIN];

  always_comb begin
    pad_d.out = lat_q;
    pad_d.oe_n = dir_q;
    if (ccp_drv) begin
      pad_d.out[bpp_pkg::CCP_PIN] = ccp_i.ccp_out;
      if (ccp_i.pwm_sel && ccp_i.pwm_tri)
        pad_d.oe_n[bpp_pkg::CCP_PIN] = 1'b1;
    end
    if (prog_en_i) begin
      pad_d.oe_n[bpp_pkg::PGC_PIN] = 1'b1;
      pad_d.out[bpp_pkg::PGD_PIN] = prog_data_out_i;
      pad_d.oe_n[bpp_pkg::PGD_PIN] = ~prog_data_oe_i;
    end
    // Pull-ups drop on any pin being driven
    pad_d.pull_en = {8{~pu_n_q}} & pad_d.oe_n;
    if (prog_en_i) begin
      pad_d.pull_en[bpp_pkg::PGC_PIN] = 1'b0;
      pad_d.pull_en[bpp_pkg::PGD_PIN] = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lat_q <= bpp_pkg::LAT_RESET;
      dir_q <= bpp_pkg::DIR_RESET;
      pu_n_q <= bpp_pkg::INTC_RESET[bpp_pkg::INTC_PU_N_BIT];
      flag_q <= 1'b0;
      samp_q <= 8'h00;
      snap_q <= 4'h0;
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      samp_q <= pin_i;
      ack_q <= req;
      rdat_q <= req ? {24'h00_0000, rd_mux} : 32'h0000_0000;
      if (wr && (sel_port || sel_lat)) lat_q <= wb_dat_i[7:0];
      if (wr && sel_dir) dir_q <= wb_dat_i[7:0];
      if (wr && sel_intc) pu_n_q <= wb_dat_i[bpp_pkg::INTC_PU_N_BIT];
      if (port_touch) snap_q <= samp_q[7:4];
      // Set wins over a software clear while mismatch persists
      if (any_mism) flag_q <= 1'b1;
      else if (wr && sel_intc) flag_q <= wb_dat_i[bpp_pkg::INTC_FLAG_BIT];
    end
  end

  // Interrupt, capture and fault inputs see pins only when they are inputs; programming inputs are not gated by direction
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // Pins come out of reset as inputs, never briefly driven
      pad_q.out <= bpp_pkg::LAT_RESET;
      pad_q.oe_n <= bpp_pkg::DIR_RESET;
      pad_q.pull_en <= 8'h00;
      irq_q <= 4'h0;
      cap_q <= 1'b0;
      flt_q <= 1'b0;
      pgc_q <= 1'b0;
      pgd_q <= 1'b0;
    end else begin
      pad_q <= pad_d;
      irq_q <= samp_q[3:0] & dir_q[3:0];
      cap_q <= ccp_map & dir_q[bpp_pkg::CCP_PIN] & samp_q[bpp_pkg::CCP_PIN];
      flt_q <= fault_en_i & dir_q[bpp_pkg::FLT_PIN] & samp_q[bpp_pkg::FLT_PIN];
      pgc_q <= prog_en_i & samp_q[bpp_pkg::PGC_PIN];
      pgd_q <= prog_en_i & samp_q[bpp_pkg::PGD_PIN];
    end
  end

  assign pin_o = pad_q.out;
  assign pin_oe_n_o = pad_q.oe_n;
  assign pull_en_o = pad_q.pull_en;
  assign wb_dat_o = rdat_q;
  assign wb_ack_o = ack_q;
  assign ext_irq_o = irq_q;
  assign ccp_capture_o = cap_q;
  assign pwm_fault_o = flt_q;
  assign prog_serial_clock_o = pgc_q;
  assign prog_serial_data_o = pgd_q;
  assign port_change_flag_o = flag_q;
  assign wake_o = flag_q;

  // Pad control and pull-ups
  chk_pullup_off_output: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (pull_en_o & ~pin_oe_n_o) == 8'h00)
    else $error("pull-up on driven pin");

  chk_pullup_after_reset: assert property (
    @(posedge clk_i)
    $fell(rst_i) |-> pull_en_o == 8'h00)
    else $error("pull-up at reset");

  chk_no_drive_reset: assert property (
    @(posedge clk_i)
    $fell(rst_i) |-> pin_oe_n_o == 8'hFF)
    else $error("pin driven after reset");

  chk_input_hiz: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!prog_en_i && !ccp_drv) |=> pin_oe_n_o == $past(dir_q))
    else $error("direction not applied");

  chk_drive_latch: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!prog_en_i && !ccp_drv) |=> pin_o == $past(lat_q))
    else $error("latch not driven");

  chk_pull_shared: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !prog_en_i |=> pull_en_o == ({8{~$past(pu_n_q)}} & pin_oe_n_o))
    else $error("shared pull-up wrong");

  chk_pull_off_dis: assert property (
    @(posedge clk_i) disable iff (rst_i)
    pu_n_q |=> pull_en_o == 8'h00)
    else $error("pull-up while disabled");

  // Register bus
  chk_ack_pulse: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than a cycle");

  chk_ack_follows: assert property (
    @(posedge clk_i) disable iff (rst_i)
    req |=> wb_ack_o)
    else $error("request not acked");

  chk_no_ack_idle: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !req |=> !wb_ack_o)
    else $error("ack without request");

  chk_rdat_idle: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !req |=> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");

  chk_rdat_upper: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wb_dat_o[31:8] == 24'h00_0000)
    else $error("upper read bits set");

  chk_lat_readback: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (req && sel_lat && !wb_we_i) |=> wb_dat_o[7:0] == $past(lat_q))
    else $error("latch readback");

  chk_dir_readback: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (req && sel_dir && !wb_we_i) |=> wb_dat_o[7:0] == $past(dir_q))
    else $error("direction readback");

  chk_port_readback: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (req && sel_port && !wb_we_i) |=> wb_dat_o[7:0] == $past(samp_q))
    else $error("port readback");

  chk_intc_readback: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (req && sel_intc && !wb_we_i) |=> wb_dat_o[7:0] == $past(intc_rd))
    else $error("control readback");

  chk_lat_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr && sel_lat) |=> lat_q == $past(wb_dat_i[7:0]))
    else $error("latch write lost");

  chk_port_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr && sel_port) |=> lat_q == $past(wb_dat_i[7:0]))
    else $error("port write lost");

  chk_lat_hold: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !(wr && (sel_lat || sel_port)) |=> $stable(lat_q))
    else $error("latch changed");

  chk_dir_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr && sel_dir) |=> dir_q == $past(wb_dat_i[7:0]))
    else $error("direction write lost");

  chk_dir_hold: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !(wr && sel_dir) |=> $stable(dir_q))
    else $error("direction changed");

  chk_pu_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr && sel_intc) |=>
      pu_n_q == $past(wb_dat_i[bpp_pkg::INTC_PU_N_BIT]))
    else $error("pull-up bit write lost");

  chk_pu_hold: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !(wr && sel_intc) |=> $stable(pu_n_q))
    else $error("pull-up bit changed");

  // Change detection
  chk_sample_pins: assert property (
    @(posedge clk_i) disable iff (rst_i)
    1'b1 |=> samp_q == $past(pin_i))
    else $error("pin sample");

  chk_snap_refresh: assert property (
    @(posedge clk_i) disable iff (rst_i)
    port_touch |=> snap_q == $past(samp_q[7:4]))
    else $error("snapshot not refreshed");

  chk_snap_hold: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !port_touch |=> $stable(snap_q))
    else $error("snapshot changed");

  chk_move_no_snap: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (req && sel_port && move_src_i && !wb_we_i) |=> $stable(snap_q))
    else $error("move refreshed snapshot");

  chk_flag_on_mism: assert property (
    @(posedge clk_i) disable iff (rst_i)
    any_mism |=> flag_q)
    else $error("mismatch did not set flag");

  chk_flag_hold: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!any_mism && !(wr && sel_intc)) |=> $stable(flag_q))
    else $error("flag changed");

  chk_flag_clear: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!any_mism && wr && sel_intc && !wb_dat_i[bpp_pkg::INTC_FLAG_BIT])
      |=> !flag_q)
    else $error("flag not cleared");

  chk_wake_flag: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wake_o == port_change_flag_o)
    else $error("wake not tied to flag");

  // Channel 2 on pin 3
  chk_ccp_out: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ccp_drv |=> pin_o[bpp_pkg::CCP_PIN] == $past(ccp_i.ccp_out))
    else $error("channel output lost");

  chk_ccp_drive: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ccp_drv && !(ccp_i.pwm_sel && ccp_i.pwm_tri))
      |=> !pin_oe_n_o[bpp_pkg::CCP_PIN])
    else $error("channel not driven");

  chk_pwm_tristate: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ccp_drv && ccp_i.pwm_sel && ccp_i.pwm_tri)
      |=> pin_oe_n_o[bpp_pkg::CCP_PIN])
    else $error("shutdown not tri-stated");

  chk_ccp_unmapped: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ccp_i.map_cfg_n |=>
      pin_o[bpp_pkg::CCP_PIN] == $past(lat_q[bpp_pkg::CCP_PIN]))
    else $error("unmapped channel drove pin");

  chk_capture: assert property (
    @(posedge clk_i) disable iff (rst_i)
    1'b1 |=> ccp_capture_o == $past(ccp_map & dir_q[bpp_pkg::CCP_PIN]
      & samp_q[bpp_pkg::CCP_PIN]))
    else $error("capture input wrong");

  // Alternate inputs
  chk_ext_irq: assert property (
    @(posedge clk_i) disable iff (rst_i)
    1'b1 |=> ext_irq_o == $past(samp_q[3:0] & dir_q[3:0]))
    else $error("external interrupt inputs");

  chk_fault_gate: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !fault_en_i |=> !pwm_fault_o)
    else $error("fault input while disabled");

  chk_fault_pass: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (fault_en_i && dir_q[bpp_pkg::FLT_PIN])
      |=> pwm_fault_o == $past(samp_q[bpp_pkg::FLT_PIN]))
    else $error("fault input lost");

  // Programming pins
  chk_prog_clk_in: assert property (
    @(posedge clk_i) disable iff (rst_i)
    prog_en_i |=> pin_oe_n_o[bpp_pkg::PGC_PIN])
    else $error("programming clock driven");

  chk_prog_data_oe: assert property (
    @(posedge clk_i) disable iff (rst_i)
    prog_en_i |=> pin_oe_n_o[bpp_pkg::PGD_PIN] == !$past(prog_data_oe_i))
    else $error("programming data enable");

  chk_prog_no_pull: assert property (
    @(posedge clk_i) disable iff (rst_i)
    prog_en_i |=> pull_en_o[7:6] == 2'b00)
    else $error("pull-up on programming pins");

  chk_prog_off: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !prog_en_i |=> (!prog_serial_clock_o && !prog_serial_data_o))
    else $error("programming inputs while off");

  chk_prog_clk_follow: assert property (
    @(posedge clk_i) disable iff (rst_i)
    prog_en_i |=> prog_serial_clock_o == $past(samp_q[bpp_pkg::PGC_PIN]))
    else $error("programming clock lost");
endmodule : bpp_port

// ===== testbench/bpp_pin_model.sv
// Pin-side model: external drivers, pull-ups and a floating line
`timescale 1ns/100ps
module bpp_pin_model (
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe_n_o,
  input wire logic [7:0] pull_en_o,
  input wire logic [7:0] ext_v,
  input wire logic [7:0] ext_en,
  output logic [7:0] pin_i
);
  // A line nobody holds must not read back a convenient value
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      if (!pin_oe_n_o[b]) pin_i[b] = pin_o[b];
      else if (ext_en[b]) pin_i[b] = ext_v[b];
      else if (pull_en_o[b]) pin_i[b] = 1'b1;
      else pin_i[b] = ~pin_o[b];
    end
  end
endmodule : bpp_pin_model

// ===== testbench/tb_bidir_port_pullup_change_irq.sv
// Self-checking bench for the GPIO port
`timescale 1ns/100ps
module tb_bidir_port_pullup_change_irq;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, mv = 0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0, rdat;
  logic [7:0] ev = 8'h05, een = 8'hFF, po, poe, pu, pin, r;
  logic [3:0] eirq;
  logic ack, flag, wake, cap;
  bpp_pkg::bpp_ccp_s ccp = 5'h10;
  int failures = 0, cmp_count = 0;
  always #5 clk_i = ~clk_i;
  bpp_pin_model u_pins (.pin_o(po), .pin_oe_n_o(poe), .pull_en_o(pu),
    .ext_v(ev), .ext_en(een), .pin_i(pin));
  bpp_port u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_sel_i(4'h1), .wb_we_i(we),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .move_src_i(mv),
    .pin_i(pin), .pin_o(po), .pin_oe_n_o(poe), .pull_en_o(pu),
    .ccp_i(ccp), .fault_en_i(1'b0), .prog_en_i(1'b0),
    .prog_data_out_i(1'b0), .prog_data_oe_i(1'b0), .ext_irq_o(eirq),
    .ccp_capture_o(cap), .pwm_fault_o(), .prog_serial_clock_o(),
    .prog_serial_data_o(), .port_change_flag_o(flag), .wake_o(wake));
  task end_sim;
    $display("compares %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim
  task chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  // Ack is taken from the value present at the edge, never a fixed count
  task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    r = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  task wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wt
  task t_reset;
    bus(0, 4'hC, 0);
    chk(r, 8'h80);
    bus(0, 4'h8, 0);
    chk(r, 8'hFF);
    chk(pu, 8'h00);
    chk(poe, 8'hFF);
    $display("test reset done");
  endtask : t_reset
  task t_drive;
    bus(1, 4'h4, 8'hA5);
    bus(1, 4'h8, 8'h0F);
    bus(1, 4'hC, 8'h00);
    wt(3);
    chk(poe, 8'h0F);
    chk(po & 8'hF0, 8'hA0);
    chk(pu, 8'h0F);
    bus(0, 4'h4, 0);
    chk(r, 8'hA5);
    bus(0, 4'h0, 0);
    chk(r, 8'hA5);
    chk({4'h0, eirq}, 8'h05);
    bus(1, 4'h8, 8'hFF);
    bus(1, 4'hC, 8'h80);
    $display("test drive done");
  endtask : t_drive
  task t_change;
    ev <= 8'h00;
    wt(3);
    bus(0, 4'h0, 0);
    bus(1, 4'hC, 8'h00);
    wt(3);
    chk({6'h0, flag, wake}, 8'h00);
    ev <= 8'h20;
    wt(4);
    chk({6'h0, flag, wake}, 8'h03);
    bus(1, 4'hC, 8'h00);
    wt(3);
    chk({7'h0, flag}, 8'h01);
    mv <= 1'b1;
    bus(0, 4'h0, 0);
    mv <= 1'b0;
    bus(1, 4'hC, 8'h00);
    wt(3);
    chk({7'h0, flag}, 8'h01);
    bus(0, 4'h0, 0);
    bus(1, 4'hC, 8'h00);
    wt(3);
    chk({7'h0, flag}, 8'h00);
    // Pin 4 driven high against a low snapshot bit
    bus(1, 4'h4, 8'hB5);
    bus(1, 4'h8, 8'hEF);
    ev <= 8'h3F;
    wt(4);
    chk({7'h0, flag}, 8'h00);
    $display("test change done");
  endtask : t_change
  task t_ccp;
    bus(1, 4'h4, 8'h00);
    bus(1, 4'h8, 8'hF7);
    ccp <= 5'h0C;
    wt(3);
    chk({6'h0, po[3], poe[3]}, 8'h02);
    ccp <= 5'h0F;
    wt(3);
    chk({7'h0, poe[3]}, 8'h01);
    bus(1, 4'h8, 8'hFF);
    wt(3);
    chk({7'h0, cap}, 8'h01);
    ccp <= 5'h10;
    wt(3);
    chk({7'h0, cap}, 8'h00);
    $display("test channel done");
  endtask : t_ccp
  initial begin
    wt(4);
    rst_i <= 1'b0;
    t_reset();
    t_drive();
    t_change();
    t_ccp();
    end_sim();
  end
  initial begin
    wt(3000);
    failures++;
    end_sim();
  end
endmodule : tb_bidir_port_pullup_change_irq
